// ==== logic/utcm_pkg.sv ====
// utcm_pkg: constants and types for the unstructured tdm cell mapper
// assumes a 200 MHz system clock and a slow bipolar line sampled by it
package utcm_pkg;
  localparam int SYS_CLK_MHZ       = 200;
  localparam int PAYLOAD_OCTETS    = 47;
  localparam int PAYLOAD_BITS      = PAYLOAD_OCTETS * 8;
  localparam int BIT_CNT_W         = 9;
  localparam int LOSS_RUN_DEFAULT  = 175;
  localparam int LOSS_RUN_W        = 16;
  localparam int MARK_RETURN_BITS  = 32;
  localparam int MARK_RETURN_MIN   = 4;
  localparam int PPM_DS1           = 130;
  localparam int PPM_E1            = 50;
  localparam int PPM_J2            = 30;
  localparam int SYNC_DIV_DS1      = 130;
  localparam int SYNC_DIV_E1       = 98;
  localparam int SYNC_DIV_J2       = 32;
  localparam int DIV_W             = 8;
  localparam int PRM_W             = 16;
  localparam logic [7:0] FLAG_OCTET = 8'h7E;

  typedef enum logic [1:0] {UTCM_DS1, UTCM_E1, UTCM_J2} utcm_line_e;
  typedef enum {UTCM_IDLE, UTCM_ZERO, UTCM_POS, UTCM_NEG} utcm_code_e;

  typedef struct packed {
    logic pos;
    logic neg;
  } utcm_rail_s;

  typedef struct packed {
    logic                        valid;
    logic [PAYLOAD_BITS-1:0]     data;
    logic                        all_ones;
  } utcm_cell_s;

  typedef struct packed {
    logic [PRM_W-1:0] flags;
    logic [PRM_W-1:0] messages;
    logic [PRM_W-1:0] loss_events;
  } utcm_stat_s;
endpackage

// ==== logic/utcm_line_decoder.sv ====
// utcm_line_decoder: bipolar to binary decoding with b8zs, hdb3 or ami
// assumes rail samples arrive as one-cycle strobes from the sampler
`timescale 1ns/1ps
module utcm_line_decoder (
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  input  wire logic                 bit_stb_i,
  input  wire utcm_pkg::utcm_rail_s rail_i,
  input  wire utcm_pkg::utcm_line_e line_type_i,
  input  wire logic                 ami_sel_i,
  output logic                      bit_stb_o,
  output logic                      bit_o,
  output logic                      mark_o
);
  // four-bit delay so substitution patterns can be undone
  logic [3:0] hold_bits;
  logic [3:0] hold_vld;
  logic       last_pol;
  logic       mark_now;
  logic       pol_now;
  logic       viol;
  logic       hdb3_mode;
  logic       b8zs_mode;
  logic [3:0] next_bits;

  assign mark_now  = rail_i.pos ^ rail_i.neg;
  assign pol_now   = rail_i.pos;
  assign viol      = mark_now && (pol_now == last_pol);
  assign hdb3_mode = (line_type_i == utcm_pkg::UTCM_E1);
  assign b8zs_mode = !hdb3_mode && !ami_sel_i;
  // violations in b8zs sit at bits 4 and 7 of 000VB0VB; each one clears the held pattern
  assign next_bits = (viol && b8zs_mode) ? 4'h0 :
                     (viol && hdb3_mode) ? {hold_bits[3], 3'h0} : hold_bits;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      hold_bits <= 4'h0;
      hold_vld  <= 4'h0;
      last_pol  <= 1'b0;
      bit_stb_o <= 1'b0;
      bit_o     <= 1'b0;
      mark_o    <= 1'b0;
    end else begin
      bit_stb_o <= bit_stb_i && hold_vld[3];
      if (bit_stb_i) begin
        bit_o     <= next_bits[3];
        mark_o    <= mark_now;
        hold_bits <= {next_bits[2:0], mark_now && !(viol && !ami_sel_i)};
        hold_vld  <= {hold_vld[2:0], 1'b1};
        if (mark_now) begin
          last_pol <= pol_now;
        end
      end
    end
  end
endmodule

// ==== logic/utcm_mapper.sv ====
// utcm_mapper: unstructured ds1/e1/j2 line to 47-octet cell payload mapper
// assumes cell consumer takes cell_o on its valid pulse; line pins are async
`timescale 1ns/1ps
module utcm_mapper #(
  parameter int LOSS_RUN = utcm_pkg::LOSS_RUN_DEFAULT
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  input  wire logic                 line_clk_i,
  input  wire logic                 line_pos_i,
  input  wire logic                 line_neg_i,
  input  wire utcm_pkg::utcm_line_e line_type_i,
  input  wire logic                 ami_sel_i,
  input  wire logic                 sync_mode_i,
  input  wire logic                 pm_enable_i,
  output logic                      line_clk_o,
  output logic                      line_clk_oe_n_o,
  output utcm_pkg::utcm_cell_s      cell_o,
  output logic                      signal_loss_o,
  output logic                      pm_alarm_o,
  output utcm_pkg::utcm_stat_s      stats_o
);
  localparam logic [utcm_pkg::LOSS_RUN_W-1:0] LOSS_LIMIT =
    utcm_pkg::LOSS_RUN_W'(LOSS_RUN);
  localparam logic [utcm_pkg::BIT_CNT_W-1:0] LAST_BIT =
    utcm_pkg::BIT_CNT_W'(utcm_pkg::PAYLOAD_BITS - 1);

  // pin synchronisers
  logic [1:0] clk_sync;
  logic [1:0] pos_sync;
  logic [1:0] neg_sync;
  logic       clk_prev;
  logic       rise_seen;

  // synchronous line clock divider
  logic [utcm_pkg::DIV_W-1:0] div_cnt;
  logic [utcm_pkg::DIV_W-1:0] div_half;
  logic                       sync_clk;
  logic                       sync_edge;
  logic                       samp_stb;

  // decoded bit stream
  logic dec_stb;
  logic dec_bit;
  logic dec_mark;

  // loss detection
  logic [utcm_pkg::LOSS_RUN_W-1:0] zero_run;
  logic [5:0]                      win_cnt;
  logic [5:0]                      win_marks;
  logic                            win_end;

  // payload assembly
  logic [utcm_pkg::PAYLOAD_BITS-1:0] shift_reg;
  logic [utcm_pkg::BIT_CNT_W-1:0]    bit_cnt;
  logic                              loss_in_cell;
  logic                              pay_bit;
  logic                              cell_done;

  // performance monitor flag hunt
  logic [7:0] pm_window;
  logic [2:0] ones_run;
  logic       flag_hit;
  logic       pm_active;

  function automatic logic [utcm_pkg::DIV_W-1:0] half_period(
    input utcm_pkg::utcm_line_e kind
  );
    case (kind)
      utcm_pkg::UTCM_E1: half_period = utcm_pkg::DIV_W'(utcm_pkg::SYNC_DIV_E1 / 2);
      utcm_pkg::UTCM_J2: half_period = utcm_pkg::DIV_W'(utcm_pkg::SYNC_DIV_J2 / 2);
      default:           half_period = utcm_pkg::DIV_W'(utcm_pkg::SYNC_DIV_DS1 / 2);
    endcase
  endfunction

  function automatic logic [15:0] bump(input logic [15:0] v);
    bump = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      clk_sync <= 2'h0;
      pos_sync <= 2'h0;
      neg_sync <= 2'h0;
      clk_prev <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], line_clk_i};
      pos_sync <= {pos_sync[0], line_pos_i};
      neg_sync <= {neg_sync[0], line_neg_i};
      clk_prev <= clk_sync[1];
    end
  end

  assign rise_seen = clk_sync[1] && !clk_prev;
  assign div_half  = half_period(line_type_i);
  assign sync_edge = (div_cnt == div_half - 8'h01) && sync_clk;

  // local reference divider for synchronous timing
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt  <= 8'h00;
      sync_clk <= 1'b0;
    end else if (div_cnt == div_half - 8'h01) begin
      div_cnt  <= 8'h00;
      sync_clk <= !sync_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // synchronous: drive clock out and sample on own edge; async: follow input
  assign line_clk_o      = sync_clk;
  assign line_clk_oe_n_o = !sync_mode_i;
  assign samp_stb        = sync_mode_i ? sync_edge : rise_seen;

  utcm_line_decoder u_dec (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .bit_stb_i   (samp_stb),
    .rail_i      ({pos_sync[1], neg_sync[1]}),
    .line_type_i (line_type_i),
    .ami_sel_i   (ami_sel_i && (line_type_i == utcm_pkg::UTCM_DS1)),
    .bit_stb_o   (dec_stb),
    .bit_o       (dec_bit),
    .mark_o      (dec_mark)
  );

  assign win_end = dec_stb && (win_cnt == 6'(utcm_pkg::MARK_RETURN_BITS - 1));

  // loss of signal: zero run sets, mark density over a window clears
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      zero_run      <= '0;
      win_cnt       <= 6'h00;
      win_marks     <= 6'h00;
      signal_loss_o <= 1'b0;
    end else if (dec_stb) begin
      zero_run  <= dec_mark ? '0 : (zero_run == LOSS_LIMIT ? zero_run : zero_run + 16'h0001);
      win_cnt   <= win_end ? 6'h00 : win_cnt + 6'h01;
      win_marks <= win_end ? 6'h00 : win_marks + {5'h00, dec_mark};
      if (!dec_mark && zero_run == LOSS_LIMIT - 16'h0001) begin
        signal_loss_o <= 1'b1;
      end else if (win_end && win_marks >= 6'(utcm_pkg::MARK_RETURN_MIN)) begin
        signal_loss_o <= 1'b0;
      end
    end
  end

  // line bits go into payload unaltered, alarms and link bits included, but are forced to ones while signal_loss_o is high
  assign pay_bit   = dec_bit || signal_loss_o;
  assign cell_done = dec_stb && (bit_cnt == LAST_BIT);

  // msb-first shift packs first bit into octet one bit 7
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg    <= '0;
      bit_cnt      <= '0;
      loss_in_cell <= 1'b0;
      cell_o       <= '0;
    end else begin
      cell_o.valid <= cell_done;
      if (dec_stb) begin
        shift_reg    <= {shift_reg[utcm_pkg::PAYLOAD_BITS-2:0], pay_bit};
        bit_cnt      <= cell_done ? '0 : bit_cnt + 9'h001;
        loss_in_cell <= cell_done ? 1'b0 : (loss_in_cell || signal_loss_o);
      end
      if (cell_done) begin
        cell_o.data     <= {shift_reg[utcm_pkg::PAYLOAD_BITS-2:0], pay_bit};
        cell_o.all_ones <= loss_in_cell || signal_loss_o;
      end
    end
  end

  // non-intrusive monitor: hunts link flags, counts flags and alarms; messages never count, as ones_run is 6 at every flag
  assign pm_active = pm_enable_i && (line_type_i == utcm_pkg::UTCM_DS1);
  assign flag_hit  = ({pm_window[6:0], dec_bit} == utcm_pkg::FLAG_OCTET);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pm_window  <= 8'h00;
      ones_run   <= 3'h0;
      pm_alarm_o <= 1'b0;
      stats_o    <= '0;
    end else if (!pm_active) begin
      pm_alarm_o <= 1'b0;
    end else begin
      pm_alarm_o <= signal_loss_o;
      if (dec_stb) begin
        pm_window <= {pm_window[6:0], dec_bit};
        ones_run  <= dec_bit ? (ones_run == 3'h7 ? ones_run : ones_run + 3'h1) : 3'h0;
        if (flag_hit) begin
          stats_o.flags <= bump(stats_o.flags);
          if (ones_run == 3'h0) begin
            stats_o.messages <= bump(stats_o.messages);
          end
        end
      end
      if (signal_loss_o && !pm_alarm_o) begin
        stats_o.loss_events <= bump(stats_o.loss_events);
      end
    end
  end
endmodule

// ==== bench/utcm_line_model.sv ====
// utcm_line_model: line equipment sending an 8-bit pattern as ami marks
// assumes async timing; clock stands still while en_i is low
`timescale 1ns/1ps
module utcm_line_model (
  input  wire logic       en_i,
  input  wire logic       zero_i,
  input  wire logic [7:0] pat_i,
  output logic            line_clk_o,
  output logic            pos_o,
  output logic            neg_o
);
  logic [2:0] idx = 3'h0;
  logic       pol = 1'b0;
  logic       b;
  initial line_clk_o = 1'b0;
  initial pos_o = 1'b1;
  initial neg_o = 1'b0;
  always begin
    if (en_i) begin
      b = !zero_i && pat_i[~idx];
      pos_o = b && !pol;
      neg_o = b && pol;
      pol = pol ^ b;
      idx = idx + 3'h1;
      #80 line_clk_o = 1'b1;
      #80 line_clk_o = 1'b0;
    end else begin
      idx = 3'h0;
      pol = 1'b0;
      pos_o = ~pos_o;
      neg_o = ~neg_o;
      #5;
    end
  end
endmodule

// ==== bench/utcm_mapper_monitor.sv ====
// utcm_mapper_monitor: port assertions for the cell mapper
// assumes binding into utcm_mapper
`timescale 1ns/1ps
module utcm_mapper_monitor #(
  parameter int LOSS_RUN = 8
) (
  input wire logic                 clk_sys_i,
  input wire logic                 reset_i,
  input wire logic                 line_clk_i,
  input wire logic                 line_pos_i,
  input wire logic                 line_neg_i,
  input wire utcm_pkg::utcm_line_e line_type_i,
  input wire logic                 ami_sel_i,
  input wire logic                 sync_mode_i,
  input wire logic                 pm_enable_i,
  input wire logic                 line_clk_o,
  input wire logic                 line_clk_oe_n_o,
  input wire utcm_pkg::utcm_cell_s cell_o,
  input wire logic                 signal_loss_o,
  input wire logic                 pm_alarm_o,
  input wire utcm_pkg::utcm_stat_s stats_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  oe_mode_a: assert property (line_clk_oe_n_o == !sync_mode_i)
    else $error("clock enable mismatch");
  cell_gap_a: assert property (cell_o.valid |=> !cell_o.valid [*8])
    else $error("cell spacing");
  data_hold_a: assert property (!cell_o.valid |-> $stable(cell_o.data))
    else $error("payload changed");
  ones_tag_a: assert property ($changed(cell_o.all_ones) |-> cell_o.valid)
    else $error("flag changed off cell");
  loss_flag_a: assert property ($past(signal_loss_o, 2) && signal_loss_o
    && cell_o.valid |-> cell_o.all_ones) else $error("loss cell not flagged");
  pm_gate_a: assert property ($rose(pm_alarm_o) |-> $past(pm_enable_i))
    else $error("alarm while monitor off");
  stats_gate_a: assert property (!pm_enable_i [*3] |=> $stable(stats_o.flags)
    && $stable(stats_o.messages)) else $error("stats moved while off");
  reset_clear_a: assert property (disable iff (1'b0) $past(reset_i) && reset_i
    |-> stats_o == '0 && !pm_alarm_o && !signal_loss_o) else $error("reset state");
endmodule
bind utcm_mapper utcm_mapper_monitor #(.LOSS_RUN(LOSS_RUN)) mon_u (.clk_sys_i, .reset_i,
  .line_clk_i, .line_pos_i, .line_neg_i, .line_type_i, .ami_sel_i, .sync_mode_i,
  .pm_enable_i, .line_clk_o, .line_clk_oe_n_o, .cell_o, .signal_loss_o, .pm_alarm_o,
  .stats_o);

// ==== bench/tb_utcm_mapper.sv ====
// tb_utcm_mapper: self-checking bench for the cell mapper
// assumes the line model feeds rails; decoder delays bits by 4 line bits
`timescale 1ns/1ps
module tb_utcm_mapper;
  typedef struct {
    utcm_pkg::utcm_line_e lt;
    logic                 ami;
    logic [7:0]           pat;
    logic [7:0]           oct;
  } utcm_row_s;
  utcm_row_s rows [4] = '{'{utcm_pkg::UTCM_DS1, 1'b1, 8'hA5, 8'hA5},
    '{utcm_pkg::UTCM_DS1, 1'b0, 8'h96, 8'h96}, '{utcm_pkg::UTCM_E1, 1'b0, 8'hCA, 8'hCA},
    '{utcm_pkg::UTCM_J2, 1'b0, 8'h71, 8'h71}};
  int                   divs [3] = '{utcm_pkg::SYNC_DIV_DS1, utcm_pkg::SYNC_DIV_E1,
    utcm_pkg::SYNC_DIV_J2};
  logic                 clk_sys_i = 1'b0;
  logic                 reset_i = 1'b1;
  utcm_pkg::utcm_line_e line_type_i = utcm_pkg::UTCM_DS1;
  logic                 ami_sel_i = 1'b0;
  logic                 sync_mode_i = 1'b0;
  logic                 pm_enable_i = 1'b0;
  logic                 lclk, lpos, lneg, line_clk_o, line_clk_oe_n_o;
  logic                 signal_loss_o, pm_alarm_o, prev;
  utcm_pkg::utcm_cell_s cell_o;
  utcm_pkg::utcm_stat_s stats_o;
  logic                 en = 1'b0;
  logic                 zero = 1'b0;
  logic [7:0]           pat = 8'h00;
  int                   failures = 0;
  int                   cmp_count = 0;
  int                   edges, ex;
  always #2.5 clk_sys_i = ~clk_sys_i;
  utcm_line_model line_u (.en_i(en), .zero_i(zero), .pat_i(pat), .line_clk_o(lclk),
    .pos_o(lpos), .neg_o(lneg));
  utcm_mapper #(.LOSS_RUN(8)) dut_u (.clk_sys_i, .reset_i, .line_clk_i(lclk),
    .line_pos_i(lpos), .line_neg_i(lneg), .line_type_i, .ami_sel_i, .sync_mode_i,
    .pm_enable_i, .line_clk_o, .line_clk_oe_n_o, .cell_o, .signal_loss_o, .pm_alarm_o,
    .stats_o);
  task automatic chk(input logic [375:0] got, input logic [375:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_cell;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (cell_o.valid !== 1'b1 && n < 13000);
    chk(cell_o.valid, 1'b1);
  endtask
  task automatic do_reset;
    en <= 1'b0;
    // let the model finish its bit in flight before reset
    repeat (40) @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk({cell_o.valid, signal_loss_o, pm_alarm_o, stats_o}, '0);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    en <= 1'b1;
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      line_type_i <= rows[i].lt;
      ami_sel_i <= rows[i].ami;
      pm_enable_i <= (rows[i].lt == utcm_pkg::UTCM_DS1);
      pat <= rows[i].pat;
      do_reset;
      wait_cell;
      chk(cell_o.data, {47{rows[i].oct}});
      chk(cell_o.all_ones, 1'b0);
    end
    // silent line: status, flagged cell, then a full ones cell
    @(posedge clk_sys_i);
    zero <= 1'b1;
    wait_cell;
    chk(signal_loss_o, 1'b1);
    chk(pm_alarm_o, 1'b0);
    chk(cell_o.all_ones, 1'b1);
    wait_cell;
    chk(cell_o.data, '1);
    @(posedge clk_sys_i);
    zero <= 1'b0;
    repeat (3000) @(negedge clk_sys_i);
    chk(signal_loss_o, 1'b0);
    // local timing per line type
    @(posedge clk_sys_i);
    en <= 1'b0;
    @(posedge clk_sys_i);
    sync_mode_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      line_type_i <= rows[i + 1].lt;
      repeat (300) @(negedge clk_sys_i);
      edges = 0;
      prev = line_clk_o;
      repeat (3136) begin
        @(negedge clk_sys_i);
        edges += int'(line_clk_o && !prev);
        prev = line_clk_o;
      end
      ex = 3136 / divs[i];
      chk(edges >= ex - 1 && edges <= ex + 1, 1'b1);
      chk(line_clk_oe_n_o, 1'b0);
    end
    print_verdict;
  end
  initial begin
    repeat (98000) @(posedge clk_sys_i);
    failures++;
    print_verdict;
  end
endmodule
